/* src/sas_pkg.sv */
package sas_pkg;
  localparam int SAS_RES_BITS = 10;
  localparam int SAS_CH_BITS = 3;
  localparam int SAS_CLK_MHZ = 100;

  // Register byte offsets.
  localparam logic [11:0] SAS_OFF_PER_EN = 12'h000;
  localparam logic [11:0] SAS_OFF_MODE = 12'h004;
  localparam logic [11:0] SAS_OFF_CHAN = 12'h008;
  localparam logic [11:0] SAS_OFF_WORD = 12'h00C;
  localparam logic [11:0] SAS_OFF_BYTE = 12'h010;
  localparam logic [11:0] SAS_OFF_STAT = 12'h014;

  // Field positions.
  localparam int SAS_POS_CLK_GATE = 5;
  localparam int SAS_POS_CMP_EN = 0;
  localparam int SAS_POS_TIME_LO = 1;
  localparam int SAS_POS_TIME_HI = 5;
  localparam int SAS_POS_RUN = 7;

  // Reset values.
  localparam logic [7:0] SAS_RST_PER_EN = 8'h00;
  localparam logic [7:0] SAS_RST_MODE = 8'h00;
  localparam logic [2:0] SAS_RST_CHAN = 3'h0;
  localparam logic [9:0] SAS_RST_RESULT = 10'h000;

  // Timing: sampling lasts a fixed base time, each bit step a selectable count.
  localparam int SAS_SAMPLE_NS = 500;
  localparam int SAS_SAMPLE_CYC = (SAS_SAMPLE_NS * SAS_CLK_MHZ) / 1000;
  localparam int SAS_STEP_BASE_CYC = 2;

  typedef enum logic [4:0] {
    SAS_IDLE = 5'b00001,
    SAS_SAMPLE = 5'b00010,
    SAS_TRIAL = 5'b00100,
    SAS_DECIDE = 5'b01000,
    SAS_LATCH = 5'b10000
  } sas_state_t;
endpackage

/* src/sas_apb_regs.sv */
`timescale 1ns/10ps
module sas_apb_regs
  import sas_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_clear,
  input wire logic [9:0] result_word,
  input wire logic [7:0] result_byte,
  input wire logic busy,
  input wire logic done_flag,
  output logic [7:0] peripheral_enable_reg,
  output logic [7:0] converter_mode_reg,
  output logic [2:0] channel_select_reg
);
  logic wr_en;
  logic known;

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign known = (paddr == SAS_OFF_PER_EN) || (paddr == SAS_OFF_MODE) || (paddr == SAS_OFF_CHAN) ||
                 (paddr == SAS_OFF_WORD) || (paddr == SAS_OFF_BYTE) || (paddr == SAS_OFF_STAT);
  assign pslverr = psel && penable && !known;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      peripheral_enable_reg <= SAS_RST_PER_EN;
    end else if (wr_en && paddr == SAS_OFF_PER_EN) begin
      peripheral_enable_reg <= pwdata[7:0];
    end
  end

  // A software write wins over the hardware stop of the run bit.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      converter_mode_reg <= SAS_RST_MODE;
    end else if (wr_en && paddr == SAS_OFF_MODE) begin
      converter_mode_reg <= pwdata[7:0];
    end else if (run_clear) begin
      converter_mode_reg[SAS_POS_RUN] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      channel_select_reg <= SAS_RST_CHAN;
    end else if (wr_en && paddr == SAS_OFF_CHAN) begin
      channel_select_reg <= pwdata[2:0];
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      SAS_OFF_PER_EN: prdata = {24'h000000, peripheral_enable_reg};
      SAS_OFF_MODE: prdata = {24'h000000, converter_mode_reg};
      SAS_OFF_CHAN: prdata = {29'h0, channel_select_reg};
      SAS_OFF_WORD: prdata = {16'h0000, 6'h00, result_word};
      SAS_OFF_BYTE: prdata = {24'h000000, result_byte};
      SAS_OFF_STAT: prdata = {30'h0, done_flag, busy};
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule // sas_apb_regs

/* src/sas_sequencer.sv */
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module sas_sequencer
  import sas_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_out,
  output logic comparator_enable,
  output logic sample_hold,
  output logic [2:0] channel_sel,
  output logic [9:0] tap_code,
  output logic conversion_done_irq
);
  logic [7:0] peripheral_enable_reg;
  logic [7:0] converter_mode_reg;
  logic [2:0] channel_select_reg;
  logic [15:0] result_word_reg;
  logic [7:0] result_byte_reg;
  logic cmp_s1_reg;
  logic cmp_s2_reg;
  sas_state_t state_reg;
  sas_state_t state_next;
  logic [9:0] sar_reg;
  logic [3:0] bit_idx_reg;
  logic [7:0] cnt_reg;
  logic [7:0] step_cyc;
  logic run_bit;
  logic active;
  logic run_clear;
  logic done_flag_reg;
  logic busy;
  logic cnt_zero;
  logic [7:0] sample_len_reg;
  logic [7:0] trial_len_reg;

  sas_apb_regs u_regs (
    .clk(clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .run_clear(run_clear),
    .result_word(result_word_reg[9:0]),
    .result_byte(result_byte_reg),
    .busy(busy),
    .done_flag(done_flag_reg),
    .peripheral_enable_reg(peripheral_enable_reg),
    .converter_mode_reg(converter_mode_reg),
    .channel_select_reg(channel_select_reg)
  );

  // Comparator output is analog-side, so it is synchronised first.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      cmp_s1_reg <= comparator_out;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  // Without the clock gate the sequencer treats the converter as unclocked.
  assign run_bit = converter_mode_reg[SAS_POS_RUN];
  assign active = peripheral_enable_reg[SAS_POS_CLK_GATE] && run_bit;
  assign comparator_enable = peripheral_enable_reg[SAS_POS_CLK_GATE] &&
                             converter_mode_reg[SAS_POS_CMP_EN];
  // The step time grows with the five-bit time field; two extra cycles cover the synchroniser.
  assign step_cyc = 8'(SAS_STEP_BASE_CYC) +
                    {3'h0, converter_mode_reg[SAS_POS_TIME_HI:SAS_POS_TIME_LO]};
  assign run_clear = 1'b0;
  assign busy = (state_reg != SAS_IDLE);
  assign cnt_zero = (cnt_reg == 8'h00);
  assign channel_sel = channel_select_reg;
  assign tap_code = sar_reg;
  assign sample_hold = (state_reg == SAS_SAMPLE);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SAS_IDLE: begin
        if (active) begin
          state_next = SAS_SAMPLE;
        end
      end
      SAS_SAMPLE: begin
        if (!active) begin
          state_next = SAS_IDLE;
        end else if (cnt_zero) begin
          state_next = SAS_TRIAL;
        end
      end
      SAS_TRIAL: begin
        if (!active) begin
          state_next = SAS_IDLE;
        end else if (cnt_zero) begin
          state_next = SAS_DECIDE;
        end
      end
      SAS_DECIDE: begin
        if (!active) begin
          state_next = SAS_IDLE;
        end else if (bit_idx_reg == 4'h0) begin
          state_next = SAS_LATCH;
        end else begin
          state_next = SAS_TRIAL;
        end
      end
      SAS_LATCH: begin
        state_next = active ? SAS_SAMPLE : SAS_IDLE;
      end
      default: state_next = SAS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= SAS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 8'h00;
    end else if (state_next == SAS_SAMPLE && state_reg != SAS_SAMPLE) begin
      cnt_reg <= 8'(SAS_SAMPLE_CYC - 1);
    end else if (state_next == SAS_TRIAL && state_reg != SAS_TRIAL) begin
      cnt_reg <= step_cyc - 8'h01;
    end else if (!cnt_zero) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // Trial bit is set on entering the step and decided from the comparator.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sar_reg <= 10'h000;
      bit_idx_reg <= 4'h0;
    end else begin
      case (state_reg)
        SAS_SAMPLE: begin
          if (cnt_zero) begin
            sar_reg <= 10'h200;
            bit_idx_reg <= 4'h9;
          end
        end
        SAS_DECIDE: begin
          // Comparator high means input at or above the tap.
          sar_reg[bit_idx_reg] <= cmp_s2_reg;
          if (bit_idx_reg != 4'h0) begin
            sar_reg[bit_idx_reg - 4'h1] <= 1'b1;
            bit_idx_reg <= bit_idx_reg - 4'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_word_reg <= {6'h00, SAS_RST_RESULT};
      result_byte_reg <= SAS_RST_RESULT[9:2];
    end else if (state_reg == SAS_LATCH) begin
      result_word_reg <= {6'h00, sar_reg};
      result_byte_reg <= sar_reg[9:2];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conversion_done_irq <= 1'b0;
    end else begin
      conversion_done_irq <= (state_reg == SAS_LATCH);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_flag_reg <= 1'b0;
    end else if (state_reg == SAS_LATCH) begin
      done_flag_reg <= 1'b1;
    end else if (psel && penable && !pwrite && paddr == SAS_OFF_WORD) begin
      done_flag_reg <= 1'b0;
    end
  end

  // Helper counters that measure phase lengths for the timing checks.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_len_reg <= 8'h00;
    end else if (sample_hold) begin
      sample_len_reg <= sample_len_reg + 8'h01;
    end else begin
      sample_len_reg <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trial_len_reg <= 8'h00;
    end else if (state_reg == SAS_TRIAL) begin
      trial_len_reg <= trial_len_reg + 8'h01;
    end else begin
      trial_len_reg <= 8'h00;
    end
  end

  first_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_SAMPLE && cnt_zero && active) |=> (tap_code == 10'h200))
    else $error("first trial code not half scale");
  byte_upper_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(conversion_done_irq) |-> (result_byte_reg == result_word_reg[9:2]))
    else $error("byte result not upper bits");
  latch_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_LATCH) |=> conversion_done_irq && result_word_reg[9:0] == $past(sar_reg))
    else $error("result not latched with end pulse");
  stop_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    (!active && state_reg != SAS_LATCH) |=> (state_reg == SAS_IDLE))
    else $error("conversion did not stop");
  repeat_conv_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_LATCH && active) |=> (state_reg == SAS_SAMPLE))
    else $error("conversion did not repeat");
  start_run_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_IDLE && active) |=> sample_hold)
    else $error("run did not start sampling");
  sample_time_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_TRIAL && $past(state_reg) == SAS_SAMPLE) |->
    (sample_len_reg == 8'(SAS_SAMPLE_CYC)))
    else $error("sampling time wrong");
  cmp_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    comparator_enable |-> peripheral_enable_reg[SAS_POS_CLK_GATE] && converter_mode_reg[SAS_POS_CMP_EN])
    else $error("comparator enable wrong");
  chan_sel_a: assert property (@(posedge clk) disable iff (!rstn)
    busy |-> channel_sel == channel_select_reg)
    else $error("channel mismatch");
  hold_phase_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_TRIAL || state_reg == SAS_DECIDE || state_reg == SAS_LATCH) |-> !sample_hold)
    else $error("sample switch not in hold");
  step_time_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_DECIDE) |-> (trial_len_reg == step_cyc))
    else $error("trial step time wrong");
  bit_decide_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_DECIDE) |=> (sar_reg[$past(bit_idx_reg)] == $past(cmp_s2_reg)))
    else $error("trial bit not decided by comparator");
  next_trial_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_DECIDE && bit_idx_reg != 4'h0) |=> (sar_reg[bit_idx_reg] == 1'b1))
    else $error("next trial bit not set");
  trial_low_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_TRIAL) |-> ((tap_code & ((10'h001 << bit_idx_reg) - 10'h001)) == 10'h000))
    else $error("bits below trial bit not clear");
  latch_after_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_LATCH) |-> ($past(state_reg) == SAS_DECIDE && $past(bit_idx_reg) == 4'h0))
    else $error("result latched before last bit");
  irq_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    conversion_done_irq |=> !conversion_done_irq)
    else $error("end pulse longer than one cycle");
  done_set_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_reg == SAS_LATCH) |=> done_flag_reg)
    else $error("done flag not set by latch");
  cmp_run_a: assert property (@(posedge clk) disable iff (!rstn)
    ($changed(run_bit) && $stable(converter_mode_reg[SAS_POS_CMP_EN]) &&
     $stable(peripheral_enable_reg[SAS_POS_CLK_GATE])) |-> $stable(comparator_enable))
    else $error("comparator enable follows run bit");
endmodule // sas_sequencer

/* test/sas_analog_model.sv */
`timescale 1ns/10ps
module sas_analog_model
  import sas_pkg::*;
(
  input wire logic clk,
  input wire logic comparator_enable,
  input wire logic sample_hold,
  input wire logic [2:0] channel_sel,
  input wire logic [9:0] tap_code,
  input wire logic [7:0][9:0] vin,
  output logic comparator_out
);
  logic [9:0] held;
  logic toggle = 1'b0;
  always_ff @(posedge clk) begin
    if (sample_hold) begin
      held <= vin[channel_sel];
    end
    toggle <= ~toggle;
  end
  // A disabled comparator gives no usable answer.
  assign comparator_out = comparator_enable ? (held >= tap_code) : toggle;
endmodule // sas_analog_model

/* test/testbench.sv */
`timescale 1ns/10ps
module testbench
  import sas_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h6D08424A;
  logic pready, pslverr, comparator_out, comparator_enable, sample_hold, conversion_done_irq, sh_d;
  logic [2:0] channel_sel;
  logic [9:0] tap_code, first_tap;
  logic [7:0][9:0] vin;
  logic [32:0] exp_q [$];
  logic [32:0] exp_e;
  int failures = 0, compares = 0, sh_cnt = 0, sh_len = 0, cyc = 0, irq_last = 0, irq_gap = 0;

  always #5 clk = ~clk;

  sas_sequencer u_sas_sequencer (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparator_out(comparator_out), .comparator_enable(comparator_enable), .sample_hold(sample_hold),
    .channel_sel(channel_sel), .tap_code(tap_code), .conversion_done_irq(conversion_done_irq));
  sas_analog_model u_sas_analog_model (.clk(clk), .comparator_enable(comparator_enable),
    .sample_hold(sample_hold), .channel_sel(channel_sel), .tap_code(tap_code), .vin(vin),
    .comparator_out(comparator_out));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (conversion_done_irq !== 1'b1 && n < 3000);
    check(32'(n < 3000), 32'h1);
  endtask

  // Result watcher: every completed access is checked against the oldest note.
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      exp_e = exp_q.pop_front();
      check(32'(pslverr), 32'(exp_e[32]));
      if (!pwrite) check(prdata, exp_e[31:0]);
    end
  end

  // Sampling length, first trial code and the spacing of end pulses.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sh_d <= sample_hold;
    sh_cnt <= sample_hold ? sh_cnt + 1 : 0;
    if (sh_d && !sample_hold) begin
      sh_len <= sh_cnt;
      first_tap <= tap_code;
    end
    if (conversion_done_irq === 1'b1) begin
      irq_gap <= cyc - irq_last;
      irq_last <= cyc;
    end
  end

  initial begin
    #200000;
    failures++;
    conclude();
  end

  initial begin
    logic [9:0] v;
    logic [2:0] ch;
    logic [4:0] tf;
    int n;
    for (int i = 0; i < 8; i++) vin[i] = 10'h000;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 24; a += 4) apb(1'b0, 12'(a), 32'h0, 33'h0);
    apb(1'b0, 12'h018, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h018, 32'hFFFFFFFF, {1'b1, 32'h0});
    apb(1'b1, SAS_OFF_MODE, 32'h1, 33'h0);
    check(32'(comparator_enable), 32'h0);
    apb(1'b1, SAS_OFF_PER_EN, 32'h20, 33'h0);
    check(32'(comparator_enable), 32'h1);
    apb(1'b0, SAS_OFF_PER_EN, 32'h0, {1'b0, 32'h20});
    repeat (100) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      v = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : seed[9:0];
      tf = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : seed[14:10];
      ch = seed[17:15];
      for (int i = 0; i < 8; i++) vin[i] <= (3'(i) == ch) ? v : ~v;
      apb(1'b1, SAS_OFF_CHAN, {29'h0, ch}, 33'h0);
      check(32'(channel_sel), 32'(ch));
      apb(1'b1, SAS_OFF_MODE, {24'h0, 2'b10, tf, 1'b1}, 33'h0);
      wait_irq();
      check(32'(sh_len), 32'(SAS_SAMPLE_CYC));
      check(32'(first_tap), 32'h200);
      vin[ch] <= ~v;
      @(posedge clk);
      check(32'(conversion_done_irq), 32'h0);
      apb(1'b0, SAS_OFF_WORD, 32'h0, {1'b0, 22'h0, v});
      apb(1'b0, SAS_OFF_BYTE, 32'h0, {1'b0, 24'h0, v[9:2]});
      apb(1'b0, SAS_OFF_STAT, 32'h0, {1'b0, 32'h1});
      wait_irq();
      @(posedge clk);
      check(32'(irq_gap), 32'(SAS_SAMPLE_CYC + 10 * (SAS_STEP_BASE_CYC + tf + 1) + 1));
      apb(1'b0, SAS_OFF_WORD, 32'h0, {1'b0, 22'h0, ~v});
      apb(1'b1, SAS_OFF_MODE, 32'h1, 33'h0);
      n = 0;
      repeat (600) begin
        @(posedge clk);
        if (conversion_done_irq !== 1'b0) n++;
      end
      check(32'(n), 32'h0);
      apb(1'b0, SAS_OFF_STAT, 32'h0, 33'h0);
      check(32'(comparator_enable), 32'h1);
    end
    conclude();
  end
endmodule // testbench
